// ---- rtl/vpoc_top.sv ----
// Video port output configuration: register pair, bit rotation, masking and float control
//
// Notes on behaviour
// - Drive enable clear floats every port output
// - Dark enable passes every dark pixel flagged by pix_dark
// - Master with dark pixels: line sync on first
// - Edge select bit inverts active pixel clock edge
// - Rotation code n puts MSB on bit 9-n
// - Code 1010 routes bits straight through
// - Global float bit floats all outputs except overridden syncs and pixel clock in master mode, resets clear
// - Per-signal override bits keep their signal driven in master mode
// - Frame sync override works in master mode
// - Line sync override works in master mode
// - Pixel clock override works in master mode
// - External sync override works in master mode
`timescale 1ns/1ns
`include "vpoc_cfg.svh"

module vpoc_top
  import vpoc_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Internal timing and converter
  input  wire logic       master_mode,
  input  wire logic [9:0] adc_word,
  input  wire logic       pix_valid,
  input  wire logic       pix_dark,
  input  wire logic       row_first_dark,
  input  wire logic       row_first_active,
  input  wire logic       row_end,
  input  wire logic       frame_sync_in,
  input  wire logic       pixel_clock_in,
  input  wire logic       external_sync_in,
  // Video port
  output vpoc_pins_t      port_out,
  output vpoc_oe_t        port_oe,
  output logic            data_valid
);

  vpoc_state_t state;
  vpoc_state_t next_state;
  logic [3:0]  shift;
  logic [3:0]  eff_shift;
  logic [9:0]  rotated;
  logic        drive_en;
  logic        dark_en;
  logic        global_float;
  logic        line_start;

  assign shift        = state.video_bus_format[`VPOC_FMT_SHIFT_HI:`VPOC_FMT_SHIFT_LO];
  assign drive_en     = state.video_bus_format[`VPOC_FMT_DRIVE_EN];
  assign dark_en      = state.video_bus_format[`VPOC_FMT_DARK_EN];
  assign global_float = state.video_output_float_control[`VPOC_FLT_GLOBAL];
  // Codes past nine route straight through
  assign eff_shift    = (shift > `VPOC_SHIFT_MAX) ? 4'h0 : shift;

  // Bit i of the bus takes converter bit (i+n) mod 10
  genvar gi;
  generate
    for (gi = 0; gi < `VPOC_DATA_BITS; gi++) begin : g_rot
      logic [4:0] src;
      logic [4:0] src_wrap;
      assign src         = 5'(gi) + {1'b0, eff_shift};
      assign src_wrap    = (src >= 5'(`VPOC_DATA_BITS)) ? src - 5'(`VPOC_DATA_BITS) : src;
      assign rotated[gi] = adc_word[src_wrap[3:0]];
    end
  endgenerate

  // In master mode line sync goes active on the first dark pixel when those are shown
  assign line_start = (master_mode && dark_en) ? row_first_dark : row_first_active;

  always_comb begin
    next_state = state;
    if (reg_wr && reg_addr == `VPOC_ADDR_BUS_FORMAT) begin
      next_state.video_bus_format = reg_wdata & `VPOC_FMT_WMASK;
    end
    if (reg_wr && reg_addr == `VPOC_ADDR_FLOAT_CTRL) begin
      next_state.video_output_float_control = reg_wdata & `VPOC_FLT_WMASK;
    end
    if (reg_rd) begin
      case (reg_addr)
        `VPOC_ADDR_BUS_FORMAT: next_state.reg_rdata = state.video_bus_format;
        `VPOC_ADDR_FLOAT_CTRL: next_state.reg_rdata = state.video_output_float_control;
        default:               next_state.reg_rdata = 8'h00;
      endcase
    end
    next_state.pins.frame_sync    = frame_sync_in;
    next_state.pins.external_sync = external_sync_in;
    next_state.pins.pixel_clock   =
      pixel_clock_in ^ state.video_bus_format[`VPOC_FMT_PCLK_EDGE];
    if (line_start) begin
      next_state.pins.line_sync = 1'b1;
    end else if (row_end) begin
      next_state.pins.line_sync = 1'b0;
    end
    // Dark pixels are withheld when readout is off
    next_state.data_valid = pix_valid && (!pix_dark || dark_en);
    if (pix_valid) begin
      next_state.pins.data = rotated;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state                            <= '0;
      state.video_bus_format           <= `VPOC_FMT_RESET;
      state.video_output_float_control <= `VPOC_FLT_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Output enables from drive enable, global float and master-mode overrides
  always_comb begin
    port_oe.data          = drive_en && !global_float;
    port_oe.frame_sync    = drive_en && (!global_float || (master_mode &&
      state.video_output_float_control[`VPOC_FLT_FSYNC_OVR]));
    port_oe.line_sync     = drive_en && (!global_float || (master_mode &&
      state.video_output_float_control[`VPOC_FLT_LSYNC_OVR]));
    port_oe.pixel_clock   = drive_en && (!global_float || (master_mode &&
      state.video_output_float_control[`VPOC_FLT_PCLK_OVR]));
    port_oe.external_sync = drive_en && (!global_float || (master_mode &&
      state.video_output_float_control[`VPOC_FLT_XSYNC_OVR]));
  end

  assign port_out   = state.pins;
  assign data_valid = state.data_valid;
  assign reg_rdata  = state.reg_rdata;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  drive_off_a: assert property (!drive_en |-> port_oe == '0)
    else $error("Port driven with drive enable clear");
  dark_mask_a: assert property (pix_valid && pix_dark && !dark_en |=> !data_valid)
    else $error("Dark pixel shown while masked");
  dark_pass_a: assert property (pix_valid && pix_dark && dark_en && !reg_wr |=> data_valid)
    else $error("Dark pixel dropped while enabled");
  valid_plain_a: assert property (pix_valid && !pix_dark |=> data_valid)
    else $error("Active pixel not flagged");
  no_pix_a: assert property (!pix_valid |=> !data_valid)
    else $error("Valid flag without a pixel");

  // Line sync, pixel clock, frame sync and external sync
  lsync_dark_a: assert property (master_mode && dark_en && row_first_dark && !reg_wr
    |=> port_out.line_sync)
    else $error("Line sync missed first dark pixel");
  lsync_row_a: assert property (!(master_mode && dark_en) && row_first_active
    |=> port_out.line_sync)
    else $error("Line sync missed first active pixel");
  lsync_end_a: assert property (row_end && !line_start |=> !port_out.line_sync)
    else $error("Line sync held past row end");
  pclk_edge_a: assert property (##1 port_out.pixel_clock ==
    ($past(pixel_clock_in) ^ $past(state.video_bus_format[5])))
    else $error("Pixel clock edge select wrong");
  sync_pass_a: assert property (##1 port_out.frame_sync == $past(frame_sync_in) &&
    port_out.external_sync == $past(external_sync_in))
    else $error("Sync level not carried to port");

  // Data routing
  rotate_zero_a: assert property (pix_valid && shift == 4'h0
    |=> port_out.data == $past(adc_word))
    else $error("Straight routing wrong");
  rotate_one_a: assert property (pix_valid && shift == 4'h1
    |=> port_out.data == {$past(adc_word[0]), $past(adc_word[9:1])})
    else $error("Rotation by one wrong");
  rotate_nine_a: assert property (pix_valid && shift == 4'h9
    |=> port_out.data == {$past(adc_word[8:0]), $past(adc_word[9])})
    else $error("Rotation by nine wrong");
  data_hold_a: assert property (!pix_valid |=> $stable(port_out.data))
    else $error("Data changed without a pixel");
  straight_a: assert property (pix_valid && shift >= 4'ha
    |=> port_out.data == $past(adc_word))
    else $error("High code did not pass straight");

  // Float and overrides
  float_all_a: assert property (global_float && !master_mode |-> port_oe == '0)
    else $error("Output driven under global float");
  data_float_a: assert property (global_float |-> !port_oe.data)
    else $error("Data driven under global float");
  drive_on_a: assert property (drive_en && !global_float |-> port_oe == '1)
    else $error("Output floated while enabled");
  fs_ovr_a: assert property (drive_en && global_float && master_mode &&
    state.video_output_float_control[3] |-> port_oe.frame_sync && !port_oe.data)
    else $error("Frame sync override failed");
  fs_float_a: assert property (global_float && !state.video_output_float_control[3]
    |-> !port_oe.frame_sync)
    else $error("Frame sync driven without override");
  ls_ovr_a: assert property (drive_en && global_float && master_mode &&
    state.video_output_float_control[2] |-> port_oe.line_sync)
    else $error("Line sync override failed");
  ls_float_a: assert property (global_float && !state.video_output_float_control[2]
    |-> !port_oe.line_sync)
    else $error("Line sync driven without override");
  pc_ovr_a: assert property (drive_en && global_float && master_mode &&
    state.video_output_float_control[1] |-> port_oe.pixel_clock)
    else $error("Pixel clock override failed");
  pc_float_a: assert property (global_float && !state.video_output_float_control[1]
    |-> !port_oe.pixel_clock)
    else $error("Pixel clock driven without override");
  xs_ovr_a: assert property (drive_en && global_float && master_mode &&
    state.video_output_float_control[0] |-> port_oe.external_sync)
    else $error("External sync override failed");
  xs_float_a: assert property (global_float && !state.video_output_float_control[0]
    |-> !port_oe.external_sync)
    else $error("External sync driven without override");

  // Register port
  rsv_read_a: assert property (reg_rd && reg_addr == 8'h54 |=> reg_rdata[4] == 1'b0)
    else $error("Reserved bit read back nonzero");
  rsv_hold_a: assert property (state.video_output_float_control[7:5] == 3'h0
    && !state.video_bus_format[4])
    else $error("Reserved bit stored");
  rd_other_a: assert property (reg_rd && reg_addr != 8'h54 && reg_addr != 8'h55
    |=> reg_rdata == 8'h00)
    else $error("Unmapped read returned nonzero");

endmodule : vpoc_top

// ---- rtl/vpoc_cfg.svh ----
// Offsets, field positions and reset values of the video port output configuration
`ifndef VPOC_CFG_SVH
`define VPOC_CFG_SVH

`define VPOC_ADDR_BUS_FORMAT   8'h54
`define VPOC_ADDR_FLOAT_CTRL   8'h55

`define VPOC_FMT_DRIVE_EN      7
`define VPOC_FMT_DARK_EN       6
`define VPOC_FMT_PCLK_EDGE     5
`define VPOC_FMT_SHIFT_HI      3
`define VPOC_FMT_SHIFT_LO      0
`define VPOC_FMT_WMASK         8'hef
`define VPOC_FMT_RESET         8'hc0

`define VPOC_FLT_GLOBAL        4
`define VPOC_FLT_FSYNC_OVR     3
`define VPOC_FLT_LSYNC_OVR     2
`define VPOC_FLT_PCLK_OVR      1
`define VPOC_FLT_XSYNC_OVR     0
`define VPOC_FLT_WMASK         8'h1f
`define VPOC_FLT_RESET         8'h00

`define VPOC_SHIFT_MAX         4'h9
`define VPOC_DATA_BITS         10

`endif

// ---- rtl/vpoc_pkg.sv ----
// Types shared by the video port output configuration block
package vpoc_pkg;

  typedef struct packed {
    logic       frame_sync;
    logic       line_sync;
    logic       pixel_clock;
    logic       external_sync;
    logic [9:0] data;
  } vpoc_pins_t;

  typedef struct packed {
    logic frame_sync;
    logic line_sync;
    logic pixel_clock;
    logic external_sync;
    logic data;
  } vpoc_oe_t;

  typedef struct packed {
    logic [7:0] video_bus_format;
    logic [7:0] video_output_float_control;
    logic [7:0] reg_rdata;
    vpoc_pins_t pins;
    logic       data_valid;
  } vpoc_state_t;

endpackage : vpoc_pkg

// ---- testbench/vpoc_host.sv ----
// Host capture model: samples the video port on the selected pixel clock edge
`timescale 1ns/1ns
module vpoc_host
  import vpoc_pkg::*;
(
  // Clock
  input  wire logic       mclk,
  // Video port and edge choice
  input  wire vpoc_pins_t port_out,
  input  wire vpoc_oe_t   port_oe,
  input  wire logic       edge_fall,
  // Capture
  output logic      [9:0] captured
);
  logic [9:0] held      = 10'h000;
  logic       pclk_drv  = 1'b0;
  logic       pclk_last = 1'b0;
  logic       pclk_seen;
  logic [9:0] bus_data;
  // Floated lines show the inverse of the last driven value
  assign bus_data  = port_oe.data ? port_out.data : ~held;
  assign pclk_seen = port_oe.pixel_clock ? port_out.pixel_clock : ~pclk_drv;
  always @(posedge mclk) begin
    if (port_oe.data) begin
      held <= port_out.data;
    end
    if (port_oe.pixel_clock) begin
      pclk_drv <= port_out.pixel_clock;
    end
    pclk_last <= pclk_seen;
    if (pclk_seen != pclk_last && pclk_seen == !edge_fall) begin
      captured <= bus_data;
    end
  end
endmodule : vpoc_host

// ---- testbench/vpoc_top_tb_top.sv ----
// Register and video path tests of the video port output configuration
`timescale 1ns/1ns
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED at %0t: %h vs %h", $time, got, exp); end end
module vpoc_top_tb_top
  import vpoc_pkg::*;
;
  logic mclk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, master_mode = 0;
  logic pix_valid = 0, pix_dark = 0, row_first_dark = 0, row_first_active = 0, row_end = 0;
  logic frame_sync_in = 0, pixel_clock_in = 0, external_sync_in = 0, data_valid;
  logic edge_fall = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic [9:0] adc_word = 0, captured;
  vpoc_pins_t port_out;
  vpoc_oe_t   port_oe;
  int mismatches = 0, checks_done = 0;
  always #25 mclk = ~mclk;
  vpoc_top u_dut (.mclk(mclk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .master_mode(master_mode), .adc_word(adc_word), .pix_valid(pix_valid),
    .pix_dark(pix_dark), .row_first_dark(row_first_dark), .row_first_active(row_first_active),
    .row_end(row_end), .frame_sync_in(frame_sync_in), .pixel_clock_in(pixel_clock_in),
    .external_sync_in(external_sync_in), .port_out(port_out), .port_oe(port_oe),
    .data_valid(data_valid));
  vpoc_host u_host (.mclk(mclk), .port_out(port_out), .port_oe(port_oe),
    .edge_fall(edge_fall), .captured(captured));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk); reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk); reg_wr <= 0;
    @(negedge mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk); reg_rd <= 1; reg_addr <= a;
    @(posedge mclk); reg_rd <= 0;
    @(negedge mclk); `CHK(reg_rdata, e)
  endtask : rd
  task automatic pix(input logic [9:0] w, input logic dk);
    @(posedge mclk); pix_valid <= 1; adc_word <= w; pix_dark <= dk;
    @(posedge mclk); pix_valid <= 0;
    @(negedge mclk);
  endtask : pix
  task automatic complete_run;
    $display("Counts: %0d checks, %0d mismatches", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1;
    rd(8'h54, 8'hc0);
    rd(8'h55, 8'h00);
    rd(8'h56, 8'h00);
    wr(8'h54, 8'hff); rd(8'h54, 8'hef);
    wr(8'h55, 8'hff); rd(8'h55, 8'h1f);
    wr(8'h55, 8'h00);
    $display("Test registers done");
    for (int n = 0; n < 16; n++) begin
      wr(8'h54, 8'hc0 | n[7:0]);
      pix(10'h200, 0);
      `CHK(port_out.data, 10'h200 >> (n > 9 ? 0 : n))
      `CHK(data_valid, 1'b1)
    end
    $display("Test rotation done");
    wr(8'h55, 8'h10); `CHK(port_oe, 5'b00000)
    @(posedge mclk); master_mode <= 1;
    wr(8'h55, 8'h1f); `CHK(port_oe, 5'b11110)
    wr(8'h55, 8'h18); `CHK(port_oe, 5'b10000)
    wr(8'h54, 8'h40); `CHK(port_oe, 5'b00000)
    wr(8'h55, 8'h00); `CHK(port_oe, 5'b00000)
    $display("Test float done");
    wr(8'h54, 8'h80); pix(10'h155, 1); `CHK(data_valid, 1'b0)
    wr(8'h54, 8'hc0); pix(10'h2aa, 1); `CHK(data_valid, 1'b1)
    `CHK(port_oe, 5'b11111)
    @(posedge mclk); row_first_dark <= 1;
    @(posedge mclk); row_first_dark <= 0;
    @(negedge mclk); `CHK(port_out.line_sync, 1'b1)
    @(posedge mclk); row_end <= 1;
    @(posedge mclk); row_end <= 0;
    @(negedge mclk); `CHK(port_out.line_sync, 1'b0)
    wr(8'h54, 8'he0); @(negedge mclk); `CHK(port_out.pixel_clock, 1'b1)
    @(posedge mclk); edge_fall <= 1;
    pix(10'h3c5, 0); `CHK(data_valid, 1'b1)
    @(posedge mclk); pixel_clock_in <= 1;
    repeat (2) @(posedge mclk);
    @(negedge mclk); `CHK(captured, 10'h3c5)
    $display("Test video done");
    complete_run();
  end
endmodule : vpoc_top_tb_top
